// >>> qpd_top.sv
`timescale 1ns/100ps
module qpd_top
    import qpd_pkg::*;
(
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RST_N,
    // Control port, open drain data
    input  wire logic                          SCL,
    input  wire logic                          SDA_IN,
    output logic                               SDA_OUT,
    output logic                               SDA_OE_N,
    // Event sources
    input  wire logic                          THERMAL_TRIP,
    input  wire logic                          SYNC_DONE,
    input  wire logic [NUM_CHAN-1:0]           OVERRANGE,
    input  wire logic                          MUTE_PIN,
    // Sample path
    input  wire logic [NUM_CHAN-1:0][SAMPLE_W-1:0] SAMPLE_IN,
    output logic      [NUM_CHAN-1:0][SAMPLE_W-1:0] SAMPLE_OUT,
    // Analog controls
    output logic                               ANALOG_ON,
    output logic                               THERMAL_SENSE_ON,
    output logic                               REFERENCE_FILTER_PIN_CLAMP
);
    // Bus slave state
    qpd_bus_state_t bus_state_reg, bus_state_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic       full_reg, full_next;
    logic       rw_reg, rw_next;
    logic       oe_n_reg, oe_n_next;
    logic       scl_prev_reg, sda_prev_reg;
    logic       wr_en, rd_clr;
    logic [7:0] rd_data;
    logic       scl_rise, scl_fall, bus_start, bus_stop;

    // Register and power state
    logic [7:0]            power_ctrl_reg, power_ctrl_next;
    qpd_event_t            status_reg, status_next, status_set;
    qpd_pwr_state_t        pwr_state_reg, pwr_state_next;
    logic [7:0]            pwr_cnt_reg, pwr_cnt_next;
    logic                  done_pulse, shut_req;
    logic                  analog_on_reg, therm_on_reg, clamp_reg;
    logic [NUM_CHAN-1:0][7:0] gains;

    assign scl_rise  = SCL & ~scl_prev_reg;
    assign scl_fall  = ~SCL & scl_prev_reg;
    assign bus_start = SCL & scl_prev_reg & sda_prev_reg & ~SDA_IN;
    assign bus_stop  = SCL & scl_prev_reg & ~sda_prev_reg & SDA_IN;

    // Read mux; reserved power bits and unmapped bytes read as zero
    always_comb begin
        rd_data = READ_UNMAPPED;
        if (ptr_reg == ADDR_POWER) begin
            rd_data = power_ctrl_reg & PWR_WRITE_MASK;
        end else if (ptr_reg == ADDR_STATUS) begin
            rd_data = status_reg;
        end
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (ptr_reg == GAIN_ADDRS[i]) begin
                rd_data = gains[i];
            end
        end
    end

    // Control port byte engine
    always_comb begin
        bus_state_next = bus_state_reg;
        bit_cnt_next   = bit_cnt_reg;
        shift_next     = shift_reg;
        ptr_next       = ptr_reg;
        full_next      = full_reg;
        rw_next        = rw_reg;
        oe_n_next      = oe_n_reg;
        wr_en          = 1'b0;
        rd_clr         = 1'b0;
        if (bus_stop) begin
            bus_state_next = BUS_IDLE;
            oe_n_next      = 1'b1;
        end else if (bus_start) begin
            bus_state_next = BUS_ADDR;
            bit_cnt_next   = '0;
            full_next      = 1'b0;
            oe_n_next      = 1'b1;
        end else begin
            case (bus_state_reg)
                BUS_ADDR, BUS_PTR, BUS_WDATA: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], SDA_IN};
                        bit_cnt_next = bit_cnt_reg + 3'h1;
                        full_next    = (bit_cnt_reg == BIT_LAST);
                    end else if (scl_fall && full_reg) begin
                        full_next    = 1'b0;
                        bit_cnt_next = '0;
                        oe_n_next    = 1'b0;
                        if (bus_state_reg == BUS_ADDR) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                rw_next        = shift_reg[0];
                                bus_state_next = BUS_ADDR_ACK;
                            end else begin
                                oe_n_next      = 1'b1;
                                bus_state_next = BUS_IDLE;
                            end
                        end else if (bus_state_reg == BUS_PTR) begin
                            ptr_next       = shift_reg;
                            bus_state_next = BUS_PTR_ACK;
                        end else begin
                            wr_en          = 1'b1;
                            ptr_next       = ptr_reg + 8'h01;
                            bus_state_next = BUS_WDATA_ACK;
                        end
                    end
                end
                BUS_ADDR_ACK, BUS_RDATA_ACK: begin
                    if (bus_state_reg == BUS_RDATA_ACK && scl_rise
                        && SDA_IN) begin
                        bus_state_next = BUS_IDLE;
                    end else if (scl_fall && (rw_reg ||
                                 bus_state_reg == BUS_RDATA_ACK)) begin
                        // Status is cleared as it is captured
                        shift_next     = rd_data;
                        oe_n_next      = rd_data[7];
                        rd_clr         = (ptr_reg == ADDR_STATUS);
                        ptr_next       = ptr_reg + 8'h01;
                        bit_cnt_next   = '0;
                        bus_state_next = BUS_RDATA;
                    end else if (scl_fall) begin
                        oe_n_next      = 1'b1;
                        bus_state_next = BUS_PTR;
                    end
                end
                BUS_PTR_ACK, BUS_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_n_next      = 1'b1;
                        bus_state_next = BUS_WDATA;
                    end
                end
                BUS_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == BIT_LAST) begin
                            oe_n_next      = 1'b1;
                            bus_state_next = BUS_RDATA_ACK;
                        end else begin
                            shift_next   = {shift_reg[6:0], 1'b0};
                            oe_n_next    = shift_reg[6];
                            bit_cnt_next = bit_cnt_reg + 3'h1;
                        end
                    end
                end
                BUS_IDLE: begin
                    oe_n_next = 1'b1;
                end
                default: begin
                    oe_n_next      = 1'b1;
                    bus_state_next = BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            bus_state_reg <= BUS_IDLE;
            bit_cnt_reg   <= '0;
            shift_reg     <= '0;
            ptr_reg       <= '0;
            full_reg      <= 1'b0;
            rw_reg        <= 1'b0;
            oe_n_reg      <= 1'b1;
            scl_prev_reg  <= 1'b1;
            sda_prev_reg  <= 1'b1;
        end else begin
            bus_state_reg <= bus_state_next;
            bit_cnt_reg   <= bit_cnt_next;
            shift_reg     <= shift_next;
            ptr_reg       <= ptr_next;
            full_reg      <= full_next;
            rw_reg        <= rw_next;
            oe_n_reg      <= oe_n_next;
            scl_prev_reg  <= SCL;
            sda_prev_reg  <= SDA_IN;
        end
    end

    // Power sequencer; the host's order of writes is trusted, not checked
    assign shut_req = power_ctrl_reg[PWR_ULP_BIT] |
                      power_ctrl_reg[PWR_LP_BIT];

    always_comb begin
        power_ctrl_next = power_ctrl_reg;
        if (wr_en && ptr_reg == ADDR_POWER) begin
            power_ctrl_next = shift_reg & PWR_WRITE_MASK;
        end
        pwr_state_next = pwr_state_reg;
        pwr_cnt_next   = pwr_cnt_reg;
        done_pulse     = 1'b0;
        case (pwr_state_reg)
            PWR_ACTIVE: begin
                if (shut_req) begin
                    pwr_state_next = PWR_SHUTTING;
                    pwr_cnt_next   = SHUTDOWN_LOAD;
                end
            end
            PWR_SHUTTING: begin
                if (pwr_cnt_reg == '0) begin
                    pwr_state_next = PWR_DOWN;
                    done_pulse     = 1'b1;
                end else begin
                    pwr_cnt_next = pwr_cnt_reg - 8'h01;
                end
            end
            PWR_DOWN: begin
                if (!shut_req) begin
                    pwr_state_next = PWR_WAKING;
                    pwr_cnt_next   = WAKE_LOAD;
                end
            end
            PWR_WAKING: begin
                if (pwr_cnt_reg == '0) begin
                    pwr_state_next = PWR_ACTIVE;
                end else begin
                    pwr_cnt_next = pwr_cnt_reg - 8'h01;
                end
            end
            default: begin
                pwr_state_next = PWR_ACTIVE;
            end
        endcase
    end

    // Sticky events; a set in the clearing cycle wins
    always_comb begin
        status_set = '0;
        status_set.shutdown_complete_flag = done_pulse;
        status_set.thermal_trip_flag      = THERMAL_TRIP & therm_on_reg;
        status_set.sync_done_flag         = SYNC_DONE;
        status_set.path2b_overrange_flag  = OVERRANGE[3];
        status_set.path2a_overrange_flag  = OVERRANGE[2];
        status_set.path1b_overrange_flag  = OVERRANGE[1];
        status_set.path1a_overrange_flag  = OVERRANGE[0];
        status_set.mute_pin_flag          = MUTE_PIN;
        status_next = (rd_clr ? qpd_event_t'(STATUS_RESET) : status_reg)
                      | status_set;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            power_ctrl_reg <= PWR_RESET;
            pwr_state_reg  <= PWR_ACTIVE;
            pwr_cnt_reg    <= '0;
            status_reg     <= qpd_event_t'(STATUS_RESET);
            analog_on_reg  <= 1'b1;
            therm_on_reg   <= 1'b1;
            clamp_reg      <= 1'b0;
        end else begin
            power_ctrl_reg <= power_ctrl_next;
            pwr_state_reg  <= pwr_state_next;
            pwr_cnt_reg    <= pwr_cnt_next;
            status_reg     <= status_next;
            analog_on_reg  <= (pwr_state_next == PWR_ACTIVE);
            therm_on_reg   <= ~power_ctrl_next[PWR_THERM_BIT];
            clamp_reg      <= power_ctrl_next[PWR_CLAMP_BIT];
        end
    end

    // Per-channel gain register and mute
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        qpd_chan u_chan (
            .clk        (CLK),
            .rst_n      (RST_N),
            .we         (wr_en && ptr_reg == GAIN_ADDRS[c]),
            .wdata      (shift_reg),
            .analog_on  (analog_on_reg),
            .sample_in  (SAMPLE_IN[c]),
            .gain       (gains[c]),
            .sample_out (SAMPLE_OUT[c])
        );
    end

    // Open drain: only ever pulls low
    always_ff @(posedge CLK) begin
        SDA_OUT <= 1'b0;
    end

    assign SDA_OE_N         = oe_n_reg;
    assign ANALOG_ON        = analog_on_reg;
    assign THERMAL_SENSE_ON = therm_on_reg;
    assign REFERENCE_FILTER_PIN_CLAMP       = clamp_reg;

endmodule : qpd_top

// >>> qpd_pkg.sv
package qpd_pkg;

    // Control port slave address (7-bit); default value is a plain choice
    localparam logic [6:0] DEV_ADDR        = 7'h48;

    // Register map
    localparam logic [7:0] ADDR_POWER      = 8'h06;
    localparam logic [7:0] ADDR_GAIN1A     = 8'h2b;
    localparam logic [7:0] ADDR_GAIN1B     = 8'h2c;
    localparam logic [7:0] ADDR_GAIN2A     = 8'h33;
    localparam logic [7:0] ADDR_GAIN2B     = 8'h34;
    localparam logic [7:0] ADDR_STATUS     = 8'h36;

    localparam int NUM_CHAN = 4;
    localparam int SAMPLE_W = 24;

    // Channel order 1A, 1B, 2A, 2B from index 0 upward
    localparam logic [NUM_CHAN-1:0][7:0] GAIN_ADDRS =
        {ADDR_GAIN2B, ADDR_GAIN2A, ADDR_GAIN1B, ADDR_GAIN1A};

    // Power control fields
    localparam int PWR_ULP_BIT   = 7;
    localparam int PWR_LP_BIT    = 6;
    localparam int PWR_CLAMP_BIT = 5;
    localparam int PWR_THERM_BIT = 4;
    localparam logic [7:0] PWR_WRITE_MASK = 8'hf0;

    // Reset values and patterns
    localparam logic [7:0] PWR_RESET    = 8'h00;
    localparam logic [7:0] GAIN_RESET   = 8'h00;
    localparam logic [7:0] GAIN_MUTE    = 8'h80;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Analog settle times
    localparam int CLK_PERIOD_NS = 100;
    localparam int SHUTDOWN_NS   = 2000;
    localparam int WAKE_NS       = 2000;
    localparam int SHUTDOWN_CYC  =
        (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC      =
        (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SHUTDOWN_LOAD = 8'(SHUTDOWN_CYC - 1);
    localparam logic [7:0] WAKE_LOAD     = 8'(WAKE_CYC - 1);

    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [1:0] {
        PWR_ACTIVE   = 2'b00,
        PWR_SHUTTING = 2'b01,
        PWR_DOWN     = 2'b11,
        PWR_WAKING   = 2'b10
    } qpd_pwr_state_t;

    typedef enum logic [3:0] {
        BUS_IDLE      = 4'b0000,
        BUS_ADDR      = 4'b0001,
        BUS_ADDR_ACK  = 4'b0011,
        BUS_PTR       = 4'b0010,
        BUS_PTR_ACK   = 4'b0110,
        BUS_WDATA     = 4'b0111,
        BUS_WDATA_ACK = 4'b0101,
        BUS_RDATA     = 4'b0100,
        BUS_RDATA_ACK = 4'b1100
    } qpd_bus_state_t;

    // Event status layout, bit 7 down to bit 0
    typedef struct packed {
        logic shutdown_complete_flag;
        logic thermal_trip_flag;
        logic sync_done_flag;
        logic path2b_overrange_flag;
        logic path2a_overrange_flag;
        logic path1b_overrange_flag;
        logic path1a_overrange_flag;
        logic mute_pin_flag;
    } qpd_event_t;

endpackage : qpd_pkg

// >>> qpd_chan.sv
`timescale 1ns/100ps
module qpd_chan
    import qpd_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Gain register write
    input  wire logic                we,
    input  wire logic [7:0]          wdata,
    input  wire logic                analog_on,
    // Sample path
    input  wire logic [SAMPLE_W-1:0] sample_in,
    output logic      [7:0]          gain,
    output logic      [SAMPLE_W-1:0] sample_out
);
    logic [7:0]          gain_reg;
    logic [7:0]          gain_next;
    logic [SAMPLE_W-1:0] sample_reg;
    logic [SAMPLE_W-1:0] sample_next;

    always_comb begin
        gain_next = we ? wdata : gain_reg;
        // Mute pattern silences the path; scaling is done downstream
        if ((gain_reg == GAIN_MUTE) || !analog_on) begin
            sample_next = '0;
        end else begin
            sample_next = sample_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_reg   <= GAIN_RESET;
            sample_reg <= '0;
        end else begin
            gain_reg   <= gain_next;
            sample_reg <= sample_next;
        end
    end

    assign gain       = gain_reg;
    assign sample_out = sample_reg;

endmodule : qpd_chan

// >>> qpd_top_props.sv
`timescale 1ns/100ps
module qpd_top_props
    import qpd_pkg::*;
(
    // Clock and reset
    input wire logic                               CLK,
    input wire logic                               RST_N,
    // Control port
    input wire logic                               SCL,
    input wire logic                               SDA_OE_N,
    // Sample path and analog controls
    input wire logic [NUM_CHAN-1:0][SAMPLE_W-1:0]  SAMPLE_OUT,
    input wire logic                               ANALOG_ON,
    input wire logic                               THERMAL_SENSE_ON,
    input wire logic                               REFERENCE_FILTER_PIN_CLAMP
);
    logic [7:0] low_cnt_reg;
    logic [7:0] low_cnt_next;

    // Saturates so a long power-down cannot wrap back to a short count
    always_comb begin
        low_cnt_next = (low_cnt_reg == 8'hff) ? low_cnt_reg
                                              : low_cnt_reg + 8'h01;
        if (ANALOG_ON) begin
            low_cnt_next = 8'h00;
        end
    end

    always_ff @(posedge CLK) begin
        low_cnt_reg <= RST_N ? low_cnt_next : 8'h00;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_scl_held;
        SCL ##1 SCL;
    endsequence

    a_mute_when_off: assert property (
        !ANALOG_ON && !$past(ANALOG_ON) |-> SAMPLE_OUT == '0)
        else $error("sample output not muted while powered down");
    a_bit_held_high: assert property (
        s_scl_held |-> $stable(SDA_OE_N))
        else $error("data line changed while bus clock high");
    a_drive_on_low: assert property (
        $changed(SDA_OE_N) |-> !SCL)
        else $error("device changed data line outside clock low");
    a_thermal_commit: assert property (
        $changed(THERMAL_SENSE_ON) |-> !SCL && !$past(SCL))
        else $error("thermal sense changed outside a write commit");
    a_clamp_commit: assert property (
        $changed(REFERENCE_FILTER_PIN_CLAMP) |-> !SCL && !$past(SCL))
        else $error("filter clamp changed outside a write commit");
    a_off_on_commit: assert property (
        $fell(ANALOG_ON) |-> !SCL)
        else $error("power-down started outside a write commit");
    a_wake_span: assert property (
        $rose(ANALOG_ON) |-> low_cnt_reg >= WAKE_LOAD)
        else $error("analog power returned too early");
endmodule : qpd_top_props

bind qpd_top qpd_top_props qpd_top_props_inst (
    .CLK              (CLK),
    .RST_N            (RST_N),
    .SCL              (SCL),
    .SDA_OE_N         (SDA_OE_N),
    .SAMPLE_OUT       (SAMPLE_OUT),
    .ANALOG_ON        (ANALOG_ON),
    .THERMAL_SENSE_ON (THERMAL_SENSE_ON),
    .REFERENCE_FILTER_PIN_CLAMP       (REFERENCE_FILTER_PIN_CLAMP)
);

// >>> qpd_host_model.sv
`timescale 1ns/100ps
module qpd_host_model
    import qpd_pkg::*;
(
    // Clock and device answer
    input  wire logic clk,
    input  wire logic sda_oe_n,
    // Bus lines as seen on the wire
    output logic      scl,
    output logic      sda
);
    logic host_rel;

    // Pulled-up wire: low whenever either party pulls it down
    assign sda = host_rel & sda_oe_n;

    initial begin
        scl = 1'b1;
        host_rel = 1'b1;
    end

    task automatic drive(input logic c, input logic d, input int n);
        scl = c;
        host_rel = d;
        repeat (n) @(posedge clk);
        #1;
    endtask : drive

    // Data moves two clocks after the clock falls, never with it
    task automatic put_bit(input logic b, output logic got);
        drive(1'b0, host_rel, 2);
        drive(1'b0, b, 3);
        drive(1'b1, b, 5);
        got = sda;
    endtask : put_bit

    // Serves as repeated start as well
    task automatic start();
        drive(1'b0, host_rel, 2);
        drive(1'b0, 1'b1, 3);
        drive(1'b1, 1'b1, 5);
        drive(1'b1, 1'b0, 5);
    endtask : start

    task automatic stop();
        drive(1'b0, host_rel, 2);
        drive(1'b0, 1'b0, 3);
        drive(1'b1, 1'b0, 5);
        drive(1'b1, 1'b1, 5);
    endtask : stop

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic got;
        for (int i = 7; i >= 0; i--) put_bit(b[i], got);
        put_bit(1'b1, got);
        ack = ~got;
    endtask : put_byte

    // Mute, power-down, clamp and wake requests
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                             input logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        put_byte({dev, 1'b0}, k0);
        put_byte(a, k1);
        put_byte(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask : write_reg

    // Status clear and poll reads; always ends with a NACK
    task automatic read_reg(input logic [7:0] a, output logic [7:0] v,
                            output logic ok);
        logic k0, k1, k2, nack;
        start();
        put_byte({DEV_ADDR, 1'b0}, k0);
        put_byte(a, k1);
        start();
        put_byte({DEV_ADDR, 1'b1}, k2);
        for (int i = 7; i >= 0; i--) put_bit(1'b1, v[i]);
        put_bit(1'b1, nack);
        stop();
        ok = k0 & k1 & k2;
    endtask : read_reg

    // Two bytes from consecutive addresses; the first one is acknowledged
    task automatic read_pair(input logic [7:0] a, output logic [15:0] v,
                             output logic ok);
        logic k0, k1, k2, nack;
        start();
        put_byte({DEV_ADDR, 1'b0}, k0);
        put_byte(a, k1);
        start();
        put_byte({DEV_ADDR, 1'b1}, k2);
        for (int i = 15; i >= 8; i--) put_bit(1'b1, v[i]);
        put_bit(1'b0, nack);
        for (int i = 7; i >= 0; i--) put_bit(1'b1, v[i]);
        put_bit(1'b1, nack);
        stop();
        ok = k0 & k1 & k2;
    endtask : read_pair
endmodule : qpd_host_model

// >>> qpd_top_tb.sv
`timescale 1ns/100ps
module qpd_top_tb
    import qpd_pkg::*;
;
    logic clk, rst_n, clk_run, scl, sda, sda_out, sda_oe_n;
    logic thermal_trip, sync_done, mute_pin;
    logic analog_on, thermal_sense_on, reference_filter_pin_clamp;
    logic [NUM_CHAN-1:0]               overrange;
    logic [NUM_CHAN-1:0][SAMPLE_W-1:0] sample_in, sample_out;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    qpd_top qpd_top_inst (.CLK(clk), .RST_N(rst_n), .SCL(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
        .THERMAL_TRIP(thermal_trip), .SYNC_DONE(sync_done),
        .OVERRANGE(overrange), .MUTE_PIN(mute_pin),
        .SAMPLE_IN(sample_in), .SAMPLE_OUT(sample_out),
        .ANALOG_ON(analog_on), .THERMAL_SENSE_ON(thermal_sense_on),
        .REFERENCE_FILTER_PIN_CLAMP(reference_filter_pin_clamp));
    qpd_host_model qpd_host_model_inst (.clk(clk), .sda_oe_n(sda_oe_n),
        .scl(scl), .sda(sda));

    // Clock holds low while stopped, as an external oscillator gated off
    initial begin
        clk = 1'b0;
        forever begin
            #50;
            clk = clk_run ? ~clk : 1'b0;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        qpd_host_model_inst.write_reg(DEV_ADDR, a, d, ok);
        check({31'h0, ok}, 32'h1, "write not acknowledged");
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                          input string m);
        logic [7:0] v;
        logic ok;
        qpd_host_model_inst.read_reg(a, v, ok);
        check({23'h0, ok, v}, {23'h0, 1'b1, e}, m);
    endtask : rd_chk

    task automatic t_reset_state();
        check({27'h0, analog_on, thermal_sense_on, reference_filter_pin_clamp, sda_out,
               sda_oe_n}, 32'h19, "pins after reset");
        rd_chk(ADDR_POWER, PWR_RESET, "power reset value");
        for (int i = 0; i < NUM_CHAN; i++)
            rd_chk(GAIN_ADDRS[i], GAIN_RESET, "gain reset value");
        rd_chk(8'h07, READ_UNMAPPED, "unmapped read");
    endtask : t_reset_state

    task automatic t_bad_addr();
        logic ok;
        qpd_host_model_inst.write_reg(DEV_ADDR ^ 7'h01, ADDR_POWER, 8'h90, ok);
        check({30'h0, ok, analog_on}, 32'h1, "foreign address");
    endtask : t_bad_addr

    task automatic t_status_events();
        {thermal_trip, sync_done, mute_pin, overrange} = 7'h75;
        tick(2);
        {thermal_trip, sync_done, mute_pin, overrange} = 7'h00;
        rd_chk(ADDR_STATUS, 8'h6b, "event flags");
        rd_chk(ADDR_STATUS, 8'h00, "flags cleared by read");
        overrange = 4'b1010;
        tick(2);
        overrange = 4'b0000;
        wr(ADDR_STATUS, 8'hff);
        rd_chk(ADDR_STATUS, 8'h14, "other paths, write ignored");
    endtask : t_status_events

    task automatic t_mute_channels();
        for (int i = 0; i < NUM_CHAN; i++) sample_in[i] = 24'h100000 + 24'(i);
        wr(GAIN_ADDRS[0], 8'h81);
        tick(2);
        check(32'(sample_out[0]), 32'(sample_in[0]),
              "near-mute passes");
        for (int i = 0; i < NUM_CHAN; i++) begin
            wr(GAIN_ADDRS[i], 8'h80);
            tick(2);
            for (int j = 0; j < NUM_CHAN; j++)
                check(32'(sample_out[j]), j <= i ? 32'h0 : 32'(sample_in[j]),
                      "channel mute");
            rd_chk(GAIN_ADDRS[i], 8'h80, "gain readback");
        end
    endtask : t_mute_channels

    task automatic t_power_down();
        logic [7:0] v;
        logic       ok;
        int         polls;
        rd_chk(ADDR_STATUS, 8'h00, "stale flags cleared");
        wr(ADDR_POWER, 8'h90);
        thermal_trip = 1'b1;
        check({30'h0, analog_on, thermal_sense_on}, 32'h0, "shutdown");
        // Bounded poll so a missing completion flag cannot hang the run
        polls = 0;
        do begin
            qpd_host_model_inst.read_reg(ADDR_STATUS, v, ok);
            polls++;
        end while (ok && v[7] !== 1'b1 && polls < 8);
        check({23'h0, ok, v}, 32'h180,
              "complete, thermal masked");
        thermal_trip = 1'b0;
        rd_chk(ADDR_STATUS, 8'h00, "completion cleared");
    endtask : t_power_down

    task automatic t_clamp_wake();
        logic [15:0] pair;
        logic        ok;
        wr(ADDR_POWER, 8'hb0);
        check({31'h0, reference_filter_pin_clamp}, 32'h1, "filter clamped");
        wr(ADDR_POWER, 8'hff);
        rd_chk(ADDR_POWER, 8'hf0, "reserved bits read zero");
        wr(ADDR_POWER, 8'h00);
        tick(WAKE_CYC + 2);
        check({29'h0, analog_on, thermal_sense_on, reference_filter_pin_clamp}, 32'h6,
              "awake, clamp off");
        wr(GAIN_ADDRS[2], GAIN_RESET);
        tick(2);
        check(32'(sample_out[2]), 32'(sample_in[2]),
              "unmuted after wake");
        qpd_host_model_inst.read_pair(ADDR_GAIN2A, pair, ok);
        check({15'h0, ok, pair}, {15'h0, 1'b1, GAIN_RESET, GAIN_MUTE},
              "two-byte read");
    endtask : t_clamp_wake

    // Full host order again: mute, clear, request, poll, then clamp
    task automatic t_stop_and_reset();
        wr(GAIN_ADDRS[2], GAIN_MUTE);
        t_power_down();
        wr(ADDR_POWER, 8'hb0);
        tick(30);
        clk_run = 1'b0;
        #2000;
        rst_n = 1'b0;
        #1000;
        clk_run = 1'b1;
        tick(10);
        rst_n = 1'b1;
        tick(1);
        check({29'h0, analog_on, thermal_sense_on, reference_filter_pin_clamp}, 32'h6,
              "pins after reset");
        rd_chk(ADDR_POWER, PWR_RESET, "power after reset");
    endtask : t_stop_and_reset

    initial begin
        clk_run = 1'b1;
        rst_n = 1'b0;
        {thermal_trip, sync_done, mute_pin, overrange} = 7'h00;
        sample_in = '0;
        tick(10);
        rst_n = 1'b1;
        tick(1);
        t_reset_state();
        t_bad_addr();
        t_status_events();
        t_mute_channels();
        t_power_down();
        t_clamp_wake();
        t_stop_and_reset();
        wrap_up();
    end
endmodule : qpd_top_tb
